// [hdl/ttc_pkg.sv]
// ttc_pkg: register map, field layout and widths of the timer unit.
// assumes an 8-bit register port and a free-running system clock.
package ttc_pkg;
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 8;
  localparam int WIDE_W   = 16;
  localparam int NARROW_W = 8;
  localparam int PRE_W    = 13;
  localparam int SEL_W    = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] WIDE_MODE_OFS     = 5'h00;
  localparam logic [ADDR_W-1:0] NA_MODE_OFS       = 5'h01;
  localparam logic [ADDR_W-1:0] NB_MODE_OFS       = 5'h02;
  localparam logic [ADDR_W-1:0] OUT_MODE_OFS      = 5'h03;
  localparam logic [ADDR_W-1:0] WIDE_HI_MSB_OFS   = 5'h04;
  localparam logic [ADDR_W-1:0] WIDE_HI_LSB_OFS   = 5'h05;
  localparam logic [ADDR_W-1:0] WIDE_LO_MSB_OFS   = 5'h06;
  localparam logic [ADDR_W-1:0] WIDE_LO_LSB_OFS   = 5'h07;
  localparam logic [ADDR_W-1:0] NA_HI_OFS         = 5'h08;
  localparam logic [ADDR_W-1:0] NA_LO_OFS         = 5'h09;
  localparam logic [ADDR_W-1:0] NB_DATA_OFS       = 5'h0A;
  localparam logic [ADDR_W-1:0] WIDE_CNT_MSB_OFS  = 5'h0B;
  localparam logic [ADDR_W-1:0] WIDE_CNT_LSB_OFS  = 5'h0C;
  localparam logic [ADDR_W-1:0] NA_CNT_OFS        = 5'h0D;
  localparam logic [ADDR_W-1:0] NB_CNT_OFS        = 5'h0E;
  localparam logic [ADDR_W-1:0] CAP_MSB_OFS       = 5'h0F;
  localparam logic [ADDR_W-1:0] CAP_LSB_OFS       = 5'h10;
  localparam logic [ADDR_W-1:0] FLAG_OFS          = 5'h11;

  // mode register fields
  localparam int RUN_BIT     = 0;
  localparam int RESTART_BIT = 1;
  localparam int CAPTURE_BIT = 2;
  localparam int SINGLE_BIT  = 3;
  localparam int EVERY2_BIT  = 4;
  localparam int SEL_LSB     = 5;
  // output mode and flag fields
  localparam int WIDE_INIT_BIT = 0;
  localparam int NA_INIT_BIT   = 1;
  localparam int WIDE_FLAG_BIT = 0;
  localparam int NA_FLAG_BIT   = 1;
  localparam int NB_FLAG_BIT   = 2;

  // clock selects
  localparam logic [SEL_W-1:0] WIDE_SEL_TAP11 = 3'h6;
  localparam logic [SEL_W-1:0] WIDE_SEL_EVENT = 3'h7;
  localparam logic [3:0]       WIDE_TAP_HIGH  = 4'hB;
  localparam logic [3:0]       NA_TAP_SKIP    = 4'h3;
  localparam logic [3:0]       NB_TAP_BASE    = 4'h5;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
endpackage

// [hdl/ttc_top.sv]
// ttc_top: three up-counters on prescaler taps or the event input, with compare, toggle outputs and capture.
// assumes one 100 MHz mclk; pins are asynchronous and resynchronised here.
// How it works
// - one 16-bit counter and two 8-bit counters, each with compare data
// - wide counter clocked by taps 0..5, tap 11 or the event input
// - narrow a clocked by taps 0..3 or 7..10
// - narrow b clocked by taps 5..12
// - wide and narrow a clear to zero on match and raise timeout
// - narrow counters never take the event input
// - run bit pauses and resumes without clearing the count
// - wide and narrow a count only while run and restart bits are both one; narrow b counts on restart alone
// - capture enable measures period on second interrupt pin, captured value readable
// - running count readable without disturbing it
// - reset stops all counting
// - initial level picks low or high compare data and drives output
// - single mode: match, interrupt, toggle, then stop cleared
// - modulo-n mode: repeat, toggle on each match, interrupt on each or every second match
// - every-second bit halves interrupt rate in modulo-n mode
// - narrow b clears and interrupts on match, interval timer
// - narrow b restart one clears and starts; write zero first
// - narrow b count readable at any time
// - wide uses high and low 16-bit data; narrow a two bytes; narrow b one
// - flags stay set until software clears or interrupt accepted
`timescale 1ns/1ps
module ttc_top
  import ttc_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         reset_n,
  input  wire logic [ttc_pkg::ADDR_W-1:0]   addr,
  input  wire logic [ttc_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output logic      [ttc_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                         event_clock_input_n,
  input  wire logic                         second_ext_irq_pin,
  input  wire logic [2:0]                   irq_accept,
  output logic                              wide_timeout_request,
  output logic                              narrow_a_timeout_request,
  output logic                              narrow_b_timeout_request,
  output logic [2:0]                        timeout_flags,
  output logic                              wide_toggle_output,
  output logic                              narrow_a_toggle_output
);
  import ttc_pkg::*;

  // tap k ticks as its low bits all reach one
  function automatic logic tap_tick(input logic [PRE_W-1:0] pre, input logic [3:0] k);
    logic [PRE_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < PRE_W; i++) begin
      if (i <= int'(k)) begin
        mask[i] = 1'b1;
      end
    end
    return (pre & mask) == mask;
  endfunction

  logic                rst_meta_n;
  logic                rst_n;
  logic [PRE_W-1:0]    prescaler_tap;
  logic [DATA_W-1:0]   wide_mode_reg;
  logic [DATA_W-1:0]   narrow_a_mode_reg;
  logic [DATA_W-1:0]   narrow_b_mode_reg;
  logic [DATA_W-1:0]   shared_output_mode_reg;
  logic [WIDE_W-1:0]   wide_hi_data;
  logic [WIDE_W-1:0]   wide_lo_data;
  logic [NARROW_W-1:0] narrow_a_hi_data;
  logic [NARROW_W-1:0] narrow_a_lo_data;
  logic [NARROW_W-1:0] narrow_b_compare_data;
  logic [WIDE_W-1:0]   wide_count;
  logic [NARROW_W-1:0] narrow_a_count;
  logic [NARROW_W-1:0] narrow_b_count;
  logic [WIDE_W-1:0]   capture_value;
  logic                wide_done;
  logic                narrow_a_done;
  logic                wide_phase;
  logic                narrow_a_phase;
  logic [1:0]          event_sync;
  logic                event_prev;
  logic [1:0]          capture_sync;
  logic                capture_prev;

  // mode decode
  logic wide_count_run, wide_restart, capture_enable, wide_single_mode, wide_irq_every_second;
  logic narrow_a_count_run, narrow_a_restart, narrow_a_single_mode, narrow_a_irq_every_second;
  logic narrow_b_restart;
  logic wide_out_initial_level, narrow_a_out_initial_level;
  logic [SEL_W-1:0] wide_sel, narrow_a_sel, narrow_b_sel;

  assign wide_count_run             = wide_mode_reg[RUN_BIT];
  assign wide_restart               = wide_mode_reg[RESTART_BIT];
  assign capture_enable             = wide_mode_reg[CAPTURE_BIT];
  assign wide_single_mode           = wide_mode_reg[SINGLE_BIT];
  assign wide_irq_every_second      = wide_mode_reg[EVERY2_BIT];
  assign wide_sel                   = wide_mode_reg[SEL_LSB +: SEL_W];
  assign narrow_a_count_run         = narrow_a_mode_reg[RUN_BIT];
  assign narrow_a_restart           = narrow_a_mode_reg[RESTART_BIT];
  assign narrow_a_single_mode       = narrow_a_mode_reg[SINGLE_BIT];
  assign narrow_a_irq_every_second  = narrow_a_mode_reg[EVERY2_BIT];
  assign narrow_a_sel               = narrow_a_mode_reg[SEL_LSB +: SEL_W];
  assign narrow_b_restart           = narrow_b_mode_reg[RESTART_BIT];
  assign narrow_b_sel               = narrow_b_mode_reg[SEL_LSB +: SEL_W];
  assign wide_out_initial_level     = shared_output_mode_reg[WIDE_INIT_BIT];
  assign narrow_a_out_initial_level = shared_output_mode_reg[NA_INIT_BIT];

  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // free-running prescaler; held in reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_tap <= '0;
    end else begin
      prescaler_tap <= prescaler_tap + 1'b1;
    end
  end

  // pin synchronisers; edges seen on stage two only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_sync   <= 2'b11;
      event_prev   <= 1'b1;
      capture_sync <= 2'b00;
      capture_prev <= 1'b0;
    end else begin
      event_sync   <= {event_sync[0], event_clock_input_n};
      event_prev   <= event_sync[1];
      capture_sync <= {capture_sync[0], second_ext_irq_pin};
      capture_prev <= capture_sync[1];
    end
  end

  logic event_edge;
  logic capture_edge;
  assign event_edge   = event_prev & ~event_sync[1];
  assign capture_edge = ~capture_prev & capture_sync[1];

  // count clock selection
  logic wide_tick, narrow_a_tick, narrow_b_tick;
  always_comb begin
    if (wide_sel == WIDE_SEL_EVENT) begin
      wide_tick = event_edge;
    end else if (wide_sel == WIDE_SEL_TAP11) begin
      wide_tick = tap_tick(prescaler_tap, WIDE_TAP_HIGH);
    end else begin
      wide_tick = tap_tick(prescaler_tap, {1'b0, wide_sel});
    end
    // upper half of select skips taps 4..6
    if (narrow_a_sel[SEL_W-1]) begin
      narrow_a_tick = tap_tick(prescaler_tap, {1'b0, narrow_a_sel} + NA_TAP_SKIP);
    end else begin
      narrow_a_tick = tap_tick(prescaler_tap, {1'b0, narrow_a_sel});
    end
    narrow_b_tick = tap_tick(prescaler_tap, {1'b0, narrow_b_sel} + NB_TAP_BASE);
  end

  // compare value follows present output level
  logic [WIDE_W-1:0]   wide_cmp;
  logic [NARROW_W-1:0] narrow_a_cmp;
  assign wide_cmp     = wide_toggle_output ? wide_hi_data : wide_lo_data;
  assign narrow_a_cmp = narrow_a_toggle_output ? narrow_a_hi_data : narrow_a_lo_data;

  logic wide_go, narrow_a_go, wide_match, narrow_a_match, narrow_b_match;
  assign wide_go        = wide_count_run & wide_restart & ~wide_done;
  assign narrow_a_go    = narrow_a_count_run & narrow_a_restart & ~narrow_a_done;
  assign wide_match     = wide_go & wide_tick & (wide_count == wide_cmp);
  assign narrow_a_match = narrow_a_go & narrow_a_tick & (narrow_a_count == narrow_a_cmp);
  assign narrow_b_match = narrow_b_restart & narrow_b_tick
                          & (narrow_b_count == narrow_b_compare_data);

  logic wide_irq_now, narrow_a_irq_now;
  // modulo-n may skip every other match
  assign wide_irq_now     = wide_match & (wide_single_mode | ~wide_irq_every_second
                                          | wide_phase);
  assign narrow_a_irq_now = narrow_a_match & (narrow_a_single_mode | ~narrow_a_irq_every_second
                                              | narrow_a_phase);

  // register writes
  logic wr_flags;
  assign wr_flags = wr_stb && (addr == FLAG_OFS);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_mode_reg          <= REG_RESET;
      narrow_a_mode_reg      <= REG_RESET;
      narrow_b_mode_reg      <= REG_RESET;
      shared_output_mode_reg <= REG_RESET;
      wide_hi_data           <= '0;
      wide_lo_data           <= '0;
      narrow_a_hi_data       <= '0;
      narrow_a_lo_data       <= '0;
      narrow_b_compare_data  <= '0;
    end else if (wr_stb) begin
      if (addr == WIDE_MODE_OFS) begin
        wide_mode_reg <= wr_data;
      end else if (addr == NA_MODE_OFS) begin
        narrow_a_mode_reg <= wr_data;
      end else if (addr == NB_MODE_OFS) begin
        narrow_b_mode_reg <= wr_data;
      end else if (addr == OUT_MODE_OFS) begin
        shared_output_mode_reg <= wr_data;
      end else if (addr == WIDE_HI_MSB_OFS) begin
        wide_hi_data[WIDE_W-1:NARROW_W] <= wr_data;
      end else if (addr == WIDE_HI_LSB_OFS) begin
        wide_hi_data[NARROW_W-1:0] <= wr_data;
      end else if (addr == WIDE_LO_MSB_OFS) begin
        wide_lo_data[WIDE_W-1:NARROW_W] <= wr_data;
      end else if (addr == WIDE_LO_LSB_OFS) begin
        wide_lo_data[NARROW_W-1:0] <= wr_data;
      end else if (addr == NA_HI_OFS) begin
        narrow_a_hi_data <= wr_data;
      end else if (addr == NA_LO_OFS) begin
        narrow_a_lo_data <= wr_data;
      end else if (addr == NB_DATA_OFS) begin
        // accepted any time; a change mid-count may miss a match
        narrow_b_compare_data <= wr_data;
      end
    end
  end

  // wide counter: restart low holds cleared, capture clears on pin edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_count    <= '0;
      capture_value <= '0;
      wide_done     <= 1'b0;
      wide_phase    <= 1'b0;
    end else if (!wide_restart) begin
      wide_count <= '0;
      wide_done  <= 1'b0;
      wide_phase <= 1'b0;
    end else begin
      if (capture_enable && capture_edge) begin
        capture_value <= wide_count;
        wide_count    <= '0;
      end else if (wide_match) begin
        wide_count <= '0;
        wide_phase <= ~wide_phase;
        wide_done  <= wide_single_mode;
      end else if (wide_go && wide_tick) begin
        wide_count <= wide_count + 1'b1;
      end
    end
  end

  // narrow a counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      narrow_a_count <= '0;
      narrow_a_done  <= 1'b0;
      narrow_a_phase <= 1'b0;
    end else if (!narrow_a_restart) begin
      narrow_a_count <= '0;
      narrow_a_done  <= 1'b0;
      narrow_a_phase <= 1'b0;
    end else if (narrow_a_match) begin
      narrow_a_count <= '0;
      narrow_a_phase <= ~narrow_a_phase;
      narrow_a_done  <= narrow_a_single_mode;
    end else if (narrow_a_go && narrow_a_tick) begin
      narrow_a_count <= narrow_a_count + 1'b1;
    end
  end

  // narrow b interval counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      narrow_b_count <= '0;
    end else if (!narrow_b_restart || narrow_b_match) begin
      narrow_b_count <= '0;
    end else if (narrow_b_tick) begin
      narrow_b_count <= narrow_b_count + 1'b1;
    end
  end

  // toggle outputs: restart low parks them at the initial level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_toggle_output     <= 1'b0;
      narrow_a_toggle_output <= 1'b0;
    end else begin
      if (!wide_restart) begin
        wide_toggle_output <= wide_out_initial_level;
      end else if (wide_match) begin
        wide_toggle_output <= ~wide_toggle_output;
      end
      if (!narrow_a_restart) begin
        narrow_a_toggle_output <= narrow_a_out_initial_level;
      end else if (narrow_a_match) begin
        narrow_a_toggle_output <= ~narrow_a_toggle_output;
      end
    end
  end

  // request pulses, one mclk wide
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wide_timeout_request     <= 1'b0;
      narrow_a_timeout_request <= 1'b0;
      narrow_b_timeout_request <= 1'b0;
    end else begin
      wide_timeout_request     <= wide_irq_now;
      narrow_a_timeout_request <= narrow_a_irq_now;
      narrow_b_timeout_request <= narrow_b_match;
    end
  end

  // sticky flags: a new event beats a clear in the same cycle
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  assign flag_set = {narrow_b_timeout_request, narrow_a_timeout_request, wide_timeout_request};
  assign flag_clr = irq_accept | (wr_flags ? wr_data[2:0] : 3'h0);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flags <= 3'h0;
    end else begin
      timeout_flags <= flag_set | (timeout_flags & ~flag_clr);
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  logic [DATA_W-1:0] next_rd_data;
  always_comb begin
    next_rd_data = '0;
    if (!rd_stb) begin
      next_rd_data = '0;
    end else if (addr == WIDE_MODE_OFS) begin
      next_rd_data = wide_mode_reg;
    end else if (addr == NA_MODE_OFS) begin
      next_rd_data = narrow_a_mode_reg;
    end else if (addr == NB_MODE_OFS) begin
      next_rd_data = narrow_b_mode_reg;
    end else if (addr == OUT_MODE_OFS) begin
      next_rd_data = shared_output_mode_reg;
    end else if (addr == WIDE_HI_MSB_OFS) begin
      next_rd_data = wide_hi_data[WIDE_W-1:NARROW_W];
    end else if (addr == WIDE_HI_LSB_OFS) begin
      next_rd_data = wide_hi_data[NARROW_W-1:0];
    end else if (addr == WIDE_LO_MSB_OFS) begin
      next_rd_data = wide_lo_data[WIDE_W-1:NARROW_W];
    end else if (addr == WIDE_LO_LSB_OFS) begin
      next_rd_data = wide_lo_data[NARROW_W-1:0];
    end else if (addr == NA_HI_OFS) begin
      next_rd_data = narrow_a_hi_data;
    end else if (addr == NA_LO_OFS) begin
      next_rd_data = narrow_a_lo_data;
    end else if (addr == NB_DATA_OFS) begin
      next_rd_data = narrow_b_compare_data;
    end else if (addr == WIDE_CNT_MSB_OFS) begin
      // bytes are live, not latched; software re-reads the upper byte
      next_rd_data = wide_count[WIDE_W-1:NARROW_W];
    end else if (addr == WIDE_CNT_LSB_OFS) begin
      next_rd_data = wide_count[NARROW_W-1:0];
    end else if (addr == NA_CNT_OFS) begin
      next_rd_data = narrow_a_count;
    end else if (addr == NB_CNT_OFS) begin
      next_rd_data = narrow_b_count;
    end else if (addr == CAP_MSB_OFS) begin
      next_rd_data = capture_value[WIDE_W-1:NARROW_W];
    end else if (addr == CAP_LSB_OFS) begin
      next_rd_data = capture_value[NARROW_W-1:0];
    end else if (addr == FLAG_OFS) begin
      next_rd_data = {5'h00, timeout_flags};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule

// [verification/ttc_monitor.sv]
// ttc_monitor: port-level assertions.
// assumes a bind into ttc_top; sees its ports only.
`timescale 1ns/1ps
module ttc_monitor
  import ttc_pkg::*;
(
  input wire logic                       mclk,
  input wire logic                       reset_n,
  input wire logic [ttc_pkg::ADDR_W-1:0] addr,
  input wire logic [ttc_pkg::DATA_W-1:0] wr_data,
  input wire logic                       wr_stb,
  input wire logic                       rd_stb,
  input wire logic [ttc_pkg::DATA_W-1:0] rd_data,
  input wire logic [2:0]                 irq_accept,
  input wire logic                       wide_timeout_request,
  input wire logic                       narrow_a_timeout_request,
  input wire logic                       narrow_b_timeout_request,
  input wire logic [2:0]                 timeout_flags,
  input wire logic                       wide_toggle_output,
  input wire logic                       narrow_a_toggle_output
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [2:0] req;
  logic [2:0] sw_clr;
  logic [2:0] keep;
  assign req = {narrow_b_timeout_request, narrow_a_timeout_request, wide_timeout_request};
  assign sw_clr = (wr_stb && addr == FLAG_OFS) ? wr_data[2:0] : 3'h0;
  // flags nobody clears this cycle must survive it
  assign keep = timeout_flags & ~irq_accept & ~sw_clr;

  chk_wide_pulse_single: assert property (
    wide_timeout_request |=> !wide_timeout_request) else $error("wide pulse");
  chk_na_pulse_single: assert property (
    narrow_a_timeout_request |=> !narrow_a_timeout_request) else $error("na pulse");
  chk_nb_pulse_single: assert property (
    narrow_b_timeout_request |=> !narrow_b_timeout_request) else $error("nb pulse");
  chk_flag_follows_req: assert property (
    req != 3'h0 |=> (timeout_flags & $past(req)) == $past(req)) else $error("flag not set");
  chk_flag_holds: assert property (
    keep != 3'h0 |=> (timeout_flags & $past(keep)) == $past(keep)) else $error("flag lost");
  chk_accept_clears: assert property (
    irq_accept[1] && !narrow_a_timeout_request |=> !timeout_flags[1])
    else $error("accept kept flag");
  chk_sw_clear_flag: assert property (
    sw_clr[2] && !narrow_b_timeout_request |=> !timeout_flags[2])
    else $error("write kept flag");
  chk_wide_toggle_req: assert property (
    wide_timeout_request |-> wide_toggle_output != $past(wide_toggle_output))
    else $error("wide no toggle");
  chk_na_toggle_req: assert property (
    narrow_a_timeout_request |-> narrow_a_toggle_output != $past(narrow_a_toggle_output))
    else $error("na no toggle");
  chk_release_quiet: assert property (
    $rose(reset_n) |-> req == 3'h0 && timeout_flags == 3'h0 ##1 req == 3'h0)
    else $error("early request");
  chk_unmapped_zero: assert property (
    rd_stb && addr > FLAG_OFS |=> rd_data == 8'h00) else $error("unmapped read");
endmodule

// [verification/ttc_irq_model.sv]
// ttc_irq_model: interrupt controller stand-in accepting timeout flags.
// assumes one mclk; slow adds a nine-cycle service delay.
`timescale 1ns/1ps
module ttc_irq_model (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [2:0] timeout_flags,
  input  wire logic [2:0] accept_en,
  input  wire logic       slow,
  output logic      [2:0] irq_accept
);
  logic [2:0] pend;
  logic [3:0] wait_cnt;
  logic       go;
  assign pend = timeout_flags & accept_en;
  // one accept at a time, so a clearing flag is never acked twice
  assign go = pend != 3'h0 && irq_accept == 3'h0 && wait_cnt >= (slow ? 4'h9 : 4'h0);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_accept <= 3'h0;
      wait_cnt   <= 4'h0;
    end else if (go) begin
      irq_accept <= pend & (~pend + 3'h1);
      wait_cnt   <= 4'h0;
    end else begin
      irq_accept <= 3'h0;
      wait_cnt   <= (pend != 3'h0) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// [verification/ttc_top_bench.sv]
// ttc_top_bench: self-checking bench.
// assumes design, partner and monitor compile first.
`timescale 1ns/1ps
module ttc_top_bench;
  import ttc_pkg::*;
  logic              mclk;
  logic              reset_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              wr_stb;
  logic              rd_stb;
  logic              ev_n;
  logic              cap_pin;
  logic              slow;
  logic [2:0]        acc_en;
  logic [2:0]        irq_accept;
  logic [2:0]        flags;
  wire  [2:0]        reqs;
  logic              wout;
  logic              aout;
  int                num_errors = 0;
  int                total_checks = 0;
  int                cyc = 0;

  ttc_top dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .event_clock_input_n(ev_n),
    .second_ext_irq_pin(cap_pin), .irq_accept(irq_accept),
    .wide_timeout_request(reqs[0]), .narrow_a_timeout_request(reqs[1]),
    .narrow_b_timeout_request(reqs[2]), .timeout_flags(flags),
    .wide_toggle_output(wout), .narrow_a_toggle_output(aout));
  ttc_irq_model partner (.mclk(mclk), .reset_n(reset_n), .timeout_flags(flags),
    .accept_en(acc_en), .slow(slow), .irq_accept(irq_accept));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = {8'h00, rd_data};
  endtask
  task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    logic [15:0] h1, lo, h2;
    repeat (4) begin
      rd(a, h1);
      rd(a + 5'h01, lo);
      rd(a, h2);
      v = {h1[7:0], lo[7:0]};
      if (h1 === h2) break;
    end
  endtask
  // cycles between request pulses; 10000 means none
  task automatic gap(input int s, input bit first, output int n);
    repeat (first ? 2 : 1) begin
      n = 0;
      do begin @(negedge mclk); n++; end while (reqs[s] !== 1'b1 && n < 10000);
    end
  endtask
  task automatic rate(input int s, input logic [ADDR_W-1:0] m);
    int p, t;
    for (int k = 0; k < 8; k++) begin
      if (s == 0 && k == 7) break;
      t = (s == 2) ? k + 5 : (s == 1) ? (k < 4 ? k : k + 3) : (k < 6 ? k : 11);
      wr(m, 8'h00);
      wr(m, {k[2:0], 5'h03});
      gap(s, 1'b1, p);
      chk("tick period", 16'(2 << t), 16'(p));
    end
  endtask

  task automatic t_regs();
    logic [15:0] v;
    for (int a = 0; a < 18; a++) begin
      rd(5'(a), v);
      chk("reset value", 16'h0000, v);
    end
    wr(NB_DATA_OFS, 8'hA5);
    rd(NB_DATA_OFS, v);
    chk("nb data", 16'h00A5, v);
    wr(NB_CNT_OFS, 8'h77);
    rd(NB_CNT_OFS, v);
    chk("nb count", 16'h0000, v);
    rd(5'h1F, v);
    chk("unmapped", 16'h0000, v);
    wr(NB_DATA_OFS, 8'h00);
    wr(OUT_MODE_OFS, 8'h03);
    repeat (2) @(negedge mclk);
    chk("init high", 16'h0003, {14'h0, aout, wout});
    wr(OUT_MODE_OFS, 8'h00);
    repeat (2) @(negedge mclk);
    chk("init low", 16'h0000, {14'h0, aout, wout});
  endtask
  task automatic t_modulo();
    int p;
    logic [15:0] v;
    wr(WIDE_LO_LSB_OFS, 8'h03);
    wr(WIDE_HI_LSB_OFS, 8'h05);
    wr(WIDE_MODE_OFS, 8'h00);
    wr(WIDE_MODE_OFS, 8'h03);
    gap(0, 1'b1, p);
    chk("high period", 16'd12, 16'(p));
    gap(0, 1'b0, p);
    chk("low period", 16'd8, 16'(p));
    wr(WIDE_MODE_OFS, 8'h00);
    wr(WIDE_MODE_OFS, 8'h13);
    gap(0, 1'b1, p);
    chk("every second", 16'd20, 16'(p));
    wr(NB_MODE_OFS, 8'h00);
    wr(NB_DATA_OFS, 8'h03);
    wr(NB_MODE_OFS, 8'h02);
    gap(2, 1'b1, p);
    chk("nb interval", 16'd256, 16'(p));
    repeat (100) @(negedge mclk);
    rd(NB_CNT_OFS, v);
    chk("nb live count", 16'h0001, v);
  endtask
  task automatic t_single();
    int p;
    logic [15:0] v;
    acc_en = 3'h0;
    wr(NA_LO_OFS, 8'h04);
    wr(NA_MODE_OFS, 8'h00);
    wr(NA_MODE_OFS, 8'h0B);
    gap(1, 1'b1, p);
    chk("single stops", 16'd10000, 16'(p));
    rd(NA_CNT_OFS, v);
    chk("single count", 16'h0000, v);
    chk("single out", 16'h0001, {15'h0, aout});
    rd(FLAG_OFS, v);
    chk("flag kept", 16'h0002, v & 16'h2);
    wr(FLAG_OFS, 8'h06);
    rd(FLAG_OFS, v);
    chk("flag cleared", 16'h0000, v & 16'h2);
    acc_en = 3'h2;
    slow = 1'b1;
    wr(NA_MODE_OFS, 8'h08);
    wr(NA_MODE_OFS, 8'h0B);
    gap(1, 1'b0, p);
    repeat (20) @(negedge mclk);
    chk("accepted", 16'h0000, {15'h0, flags[1]});
    acc_en = 3'h7;
    slow = 1'b0;
  endtask
  task automatic t_pause();
    logic [15:0] c1, c2, c3;
    wr(WIDE_LO_MSB_OFS, 8'hFF);
    wr(WIDE_LO_LSB_OFS, 8'hFF);
    wr(WIDE_MODE_OFS, 8'h00);
    wr(WIDE_MODE_OFS, 8'h03);
    repeat (600) @(negedge mclk);
    rd16(WIDE_CNT_MSB_OFS, c1);
    wr(WIDE_MODE_OFS, 8'h02);
    rd16(WIDE_CNT_MSB_OFS, c2);
    repeat (50) @(negedge mclk);
    rd16(WIDE_CNT_MSB_OFS, c3);
    chk("paused", 16'h0001, 16'(c2 >= c1 && c3 == c2 && c1 > 16'd250));
    wr(WIDE_MODE_OFS, 8'h03);
    repeat (100) @(negedge mclk);
    rd16(WIDE_CNT_MSB_OFS, c1);
    chk("resumed", 16'h0001, 16'(c1 > c3));
    wr(WIDE_MODE_OFS, 8'h01);
    rd16(WIDE_CNT_MSB_OFS, c1);
    chk("held clear", 16'h0000, c1);
  endtask
  task automatic t_event_capture();
    logic [15:0] v;
    wr(WIDE_MODE_OFS, 8'h00);
    wr(WIDE_MODE_OFS, 8'hE3);
    repeat (5) begin
      @(posedge mclk) ev_n <= 1'b0;
      repeat (4) @(posedge mclk);
      ev_n <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    rd16(WIDE_CNT_MSB_OFS, v);
    chk("events", 16'd5, v);
    wr(WIDE_MODE_OFS, 8'h00);
    wr(WIDE_MODE_OFS, 8'h07);
    repeat (2) begin
      @(posedge mclk) cap_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      cap_pin <= 1'b0;
      repeat (196) @(posedge mclk);
    end
    rd16(CAP_MSB_OFS, v);
    chk("capture", 16'h0001, 16'(v >= 16'd99 && v <= 16'd101));
  endtask

  initial begin
    reset_n = 1'b0;
    addr = 5'h00;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ev_n = 1'b1;
    cap_pin = 1'b0;
    slow = 1'b0;
    acc_en = 3'h7;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    rate(0, WIDE_MODE_OFS);
    rate(1, NA_MODE_OFS);
    rate(2, NB_MODE_OFS);
    t_modulo();
    t_single();
    t_pause();
    t_event_capture();
    stop_test();
  end
endmodule

bind ttc_top ttc_monitor u_mon (.mclk(mclk), .reset_n(reset_n), .addr(addr),
  .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .irq_accept(irq_accept), .wide_timeout_request(wide_timeout_request),
  .narrow_a_timeout_request(narrow_a_timeout_request),
  .narrow_b_timeout_request(narrow_b_timeout_request), .timeout_flags(timeout_flags),
  .wide_toggle_output(wide_toggle_output), .narrow_a_toggle_output(narrow_a_toggle_output));
